/* shbg_pkg.sv */
// Shared constants and types for the serial hold and supply guard block
package shbg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin vector layout, as sampled by the three-stage synchronisers
  localparam int PIN_W      = 5;
  localparam int PIN_SI     = 0;
  localparam int PIN_SCK    = 1;
  localparam int PIN_CS_B   = 2;
  localparam int PIN_HOLD_B = 3;
  localparam int PIN_LOW    = 4;
  // Idle levels: deselected, not paused, clock low, supply good
  localparam logic [4:0] PIN_RST = 5'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes (plain defaults, adjust to the command set in use)
  localparam logic [7:0] WRITE_ENABLE_CMD        = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_STATE_CMD = 8'h04;
  localparam logic [7:0] STATUS_WRITE_CMD        = 8'h01;
  localparam logic [7:0] MEM_WRITE_CMD           = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Counters and reset values
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [1:0] BYTES_SAT   = 2'h3;
  localparam logic [1:0] BYTES_WRITE = 2'h2;
  localparam logic [1:0] BYTES_CMD   = 2'h1;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam int FIFO_DEPTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // One received byte: first marks the opcode byte of a selection
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } shbg_rx_t;

  localparam int RX_W = $bits(shbg_rx_t);

  // Link phase of the shifter
  typedef enum logic [1:0] {
    SHBG_IDLE   = 2'b00,
    SHBG_SHIFT  = 2'b01,
    SHBG_PAUSED = 2'b10
  } shbg_phase_t;

endpackage

/* shbg_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module shbg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage words
  logic [AW:0]      wr_ptr;        // Write pointer with wrap bit
  logic [AW:0]      rd_ptr;        // Read pointer with wrap bit
  wire              full;          // All words in use
  wire              empty;         // No word held
  wire              push;          // Word accepted
  wire              pop;           // Word taken

  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Pointers; storage has no reset, only valid words are ever read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Write port
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule

/* shbg_guard.sv */
// Serial link front end with pause control and low-supply write guard
`timescale 1ns/1ps
module shbg_guard
  import shbg_pkg::*;
(
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  rst_b,
  // Link pins from the host
  input  wire logic  cs_b,
  input  wire logic  sck,
  input  wire logic  si,
  input  wire logic  hold_b,
  // Serial data out, enable low while driving
  output logic       so_out,
  output logic       so_oe_b,
  // Supply-drop detector level
  input  wire logic  supply_low,
  // Transmit side
  input  wire logic  so_enable,
  input  wire logic [7:0] tx_byte,
  // Received byte stream
  output logic       rx_valid,
  input  wire logic  rx_ready,
  output shbg_rx_t   rx_data,
  // Write control and status
  output logic       write_enable_latch,
  output logic       write_start,
  output logic       write_is_status,
  output logic       write_abort,
  output logic       overrun,
  output logic       paused,
  output logic       selected
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and agreement filter
  logic [PIN_W-1:0] sync1;        // First stage, read only by sync2
  logic [PIN_W-1:0] sync2;        // Second stage
  logic [PIN_W-1:0] sync3;        // Third stage
  logic [PIN_W-1:0] filt;         // Accepted pin levels
  logic             sck_prev;     // Last accepted clock level
  logic             cs_prev;      // Last accepted select level
  logic             low_prev;     // Last accepted supply level

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= PIN_RST;
      sync2 <= PIN_RST;
      sync3 <= PIN_RST;
    end else begin
      sync1 <= {supply_low, hold_b, cs_b, sck, si};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A level counts only once two later stages agree
  generate
    for (genvar i = 0; i < PIN_W; i++) begin : g_filt
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          filt[i] <= PIN_RST[i];
        end else if (sync2[i] == sync3[i]) begin
          filt[i] <= sync3[i];
        end
      end
    end
  endgenerate

  // Previous accepted levels for edge finding
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sck_prev <= PIN_RST[PIN_SCK];
      cs_prev  <= PIN_RST[PIN_CS_B];
      low_prev <= PIN_RST[PIN_LOW];
    end else begin
      sck_prev <= filt[PIN_SCK];
      cs_prev  <= filt[PIN_CS_B];
      low_prev <= filt[PIN_LOW];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded events
  wire sck_f     = filt[PIN_SCK];               // Clock level
  wire sel       = !filt[PIN_CS_B];             // Device selected
  wire cs_rise   = filt[PIN_CS_B] && !cs_prev;  // Deselect edge
  wire cs_fall   = !filt[PIN_CS_B] && cs_prev;  // Select edge
  wire low_f     = filt[PIN_LOW];               // Supply too low
  wire low_rise  = low_f && !low_prev;          // Drop detected
  wire hold_req  = !filt[PIN_HOLD_B];           // Pause requested
  wire sck_rise  = sck_f && !sck_prev;
  wire sck_fall  = !sck_f && sck_prev;

  shbg_phase_t phase;             // Shifter phase
  shbg_phase_t next_phase;
  logic [2:0]  bit_cnt;           // Bit within the current byte
  logic [1:0]  byte_cnt;          // Whole bytes seen, saturating
  logic [7:0]  rx_shift;          // Incoming bits
  logic [7:0]  tx_shift;          // Outgoing bits
  logic [7:0]  opcode;            // First byte of this selection
  logic        tx_load;           // Reload outgoing byte at next fall

  wire hold    = (phase == SHBG_PAUSED);
  // Clock edges only count while selected and not paused
  wire live_rise = sck_rise && sel && !hold;
  wire live_fall = sck_fall && sel && !hold;
  wire byte_done = live_rise && (bit_cnt == BIT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Pause entry and exit. With the clock low the pause tracks the pin at once;
  // with it high the old state is kept, so the change lands on the fall.
  always_comb begin
    next_phase = phase;
    unique case (phase)
      SHBG_IDLE: begin
        if (cs_fall) begin
          next_phase = SHBG_SHIFT;
        end
      end
      SHBG_SHIFT: begin
        if (!sel) begin
          next_phase = SHBG_IDLE;
        end else if (!sck_f && hold_req) begin
          next_phase = SHBG_PAUSED;
        end
      end
      SHBG_PAUSED: begin
        if (!sel) begin
          next_phase = SHBG_IDLE;
        end else if (!sck_f && !hold_req) begin
          next_phase = SHBG_SHIFT;
        end
      end
      default: begin
        next_phase = SHBG_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase <= SHBG_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift path; counters clear on deselect and otherwise move only on live edges, so a pause freezes them
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt  <= '0;
      byte_cnt <= '0;
      rx_shift <= BYTE_RST;
      opcode   <= BYTE_RST;
    end else if (!sel) begin
      bit_cnt  <= '0;
      byte_cnt <= '0;
    end else if (live_rise) begin
      rx_shift <= {rx_shift[6:0], filt[PIN_SI]};
      bit_cnt  <= bit_cnt + 3'h1;
      if (bit_cnt == BIT_LAST && byte_cnt != BYTES_SAT) begin
        byte_cnt <= byte_cnt + 2'h1;
      end
      if (bit_cnt == BIT_LAST && byte_cnt == '0) begin
        opcode <= {rx_shift[6:0], filt[PIN_SI]};
      end
    end
  end

  // Outgoing byte: loaded on select, reloaded on the fall after a byte
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift <= BYTE_RST;
      tx_load  <= 1'b0;
    end else if (cs_fall) begin
      tx_shift <= tx_byte;
      tx_load  <= 1'b0;
    end else if (byte_done) begin
      tx_load  <= 1'b1;
    end else if (live_fall) begin
      tx_shift <= tx_load ? tx_byte : {tx_shift[6:0], 1'b0};
      tx_load  <= 1'b0;
    end
  end

  // Output pin: floated whenever paused or deselected
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      so_out  <= 1'b0;
      so_oe_b <= 1'b1;
    end else begin
      so_out  <= tx_shift[7];
      so_oe_b <= !(sel && !hold && so_enable && next_phase == SHBG_SHIFT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received bytes into the FIFO; a refused byte marks the selection broken
  wire      push_ready;
  shbg_rx_t push_word;

  assign push_word = '{first: (byte_cnt == '0), data: {rx_shift[6:0], filt[PIN_SI]}};

  shbg_fifo #(
    .WIDTH (RX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (byte_done),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Overrun lasts until the next selection begins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overrun <= 1'b0;
    end else if (byte_done && !push_ready) begin
      overrun <= 1'b1;
    end else if (cs_fall) begin
      overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit decode at the deselect edge. A paused deselect, a partial byte
  // or low supply cancel every commit; a lost byte cancels only a write.
  function automatic logic is_write_op(input logic [7:0] op);
    return (op == MEM_WRITE_CMD) || (op == STATUS_WRITE_CMD);
  endfunction

  wire clean_end = cs_rise && !hold && (bit_cnt == '0) && !low_f;
  wire do_write  = clean_end && is_write_op(opcode) && (byte_cnt >= BYTES_WRITE)
                   && write_enable_latch && !overrun;
  wire do_wen    = clean_end && (opcode == WRITE_ENABLE_CMD) && (byte_cnt == BYTES_CMD);
  wire do_wdis   = clean_end && (opcode == WRITE_DISABLE_STATE_CMD) && (byte_cnt == BYTES_CMD);

  // Write latch: supply drop and reset win over everything
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      write_enable_latch <= 1'b0;
    end else if (low_f) begin
      write_enable_latch <= 1'b0;
    end else if (do_write || do_wdis) begin
      write_enable_latch <= 1'b0;
    end else if (do_wen) begin
      write_enable_latch <= 1'b1;
    end
  end

  // Write start pulse and abort level; abort shows from reset on
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      write_start     <= 1'b0;
      write_is_status <= 1'b0;
      write_abort     <= 1'b1;
    end else begin
      write_start     <= do_write;
      write_is_status <= do_write ? (opcode == STATUS_WRITE_CMD) : write_is_status;
      write_abort     <= low_f || low_rise;
    end
  end

  assign paused   = hold;
  assign selected = sel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_low_clock_req;
    !sck_f && hold_req && sel;
  endsequence

  sequence s_held_deselect;
    hold && cs_rise;
  endsequence

  a_pause_floats: assert property (@(posedge clock) disable iff (!rst_b)
    hold |=> so_oe_b)
    else $error("output driven while paused");

  a_pause_freezes: assert property (@(posedge clock) disable iff (!rst_b)
    (hold && sel) |=> ($stable(bit_cnt) && $stable(rx_shift) && $stable(tx_shift)))
    else $error("shift state moved during pause");

  a_desel_cancel: assert property (@(posedge clock) disable iff (!rst_b)
    s_held_deselect |=> (!write_start && !hold) ##1 !hold)
    else $error("paused deselect did not terminate");

  a_low_enter: assert property (@(posedge clock) disable iff (!rst_b)
    (s_low_clock_req and (phase == SHBG_SHIFT)) |=> hold)
    else $error("pause not entered with clock low");

  a_high_defer: assert property (@(posedge clock) disable iff (!rst_b)
    (sck_f && sel) |=> (hold == $past(hold)))
    else $error("pause changed while clock high");

  a_low_exit: assert property (@(posedge clock) disable iff (!rst_b)
    (hold && !sck_f && !hold_req && sel) |=> !hold)
    else $error("pause not left with clock low");

  a_brown_clears: assert property (@(posedge clock) disable iff (!rst_b)
    low_f |=> (!write_enable_latch && write_abort && !write_start))
    else $error("supply drop left write armed");

  a_start_edge: assert property (@(posedge clock) disable iff (!rst_b)
    write_start |-> ($past(cs_rise) && $past(write_enable_latch) && !write_enable_latch))
    else $error("write started without deselect edge or latch");

endmodule

/* shbg_host.sv */
// Host serial controller model that drives select, clock, data and pause
`timescale 1ns/1ps
module shbg_host (
  // System clock pacing the link
  input  wire logic clock,
  // Device output as the host sees it
  input  wire logic so_out,
  input  wire logic so_oe_b,
  // Pins driven towards the device
  output logic      cs_b,
  output logic      sck,
  output logic      si,
  output logic      hold_b
);
  logic [7:0] so_seen; // Bits taken from the device as the clock rises

  ////////////////////////////////////////////////////////////
  // Idle: deselected, clock low and still, not paused
  initial begin
    cs_b    = 1'b1;
    sck     = 1'b0;
    si      = 1'b1;
    hold_b  = 1'b1;
    so_seen = 8'h00;
  end

  // Half a link period: 8 system clocks, 32 ns
  task automatic half();
    repeat (8) @(posedge clock);
  endtask

  // Select moves only with the clock low, so they never rise together
  task automatic sel(input logic on);
    half();
    cs_b <= ~on;
    if (!on) begin
      si <= ~si; // A released data line must not keep showing the last bit
      half();
    end
    half();
  endtask

  // Mode 0, MSB first; a floating output reads inverted so it never matches
  task automatic xfer(input logic [7:0] b, input int n);
    @(posedge clock);
    for (int i = 7; i > 7 - n; i--) begin
      si <= b[i];
      half();
      sck     <= 1'b1;
      so_seen <= {so_seen[6:0], so_oe_b ? ~so_out : so_out};
      half();
      sck <= 1'b0;
    end
  endtask

  // One lone clock edge with a data bit set up ahead of it
  task automatic step(input logic lvl, input logic b);
    @(posedge clock);
    si <= b;
    half();
    sck <= lvl;
    half();
  endtask

  // Pause pin; select is left at whatever level it already has
  task automatic hold(input logic on);
    half();
    hold_b <= ~on;
    half();
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the serial hold and supply guard
`timescale 1ns/1ps
module tb_top;
  import shbg_pkg::*;

  logic       clock, rst_b, cs_b, sck, si, hold_b, so_out, so_oe_b;
  logic       supply_low, so_enable, rx_valid, rx_ready, write_enable_latch;
  logic       write_start, write_is_status, write_abort, overrun, paused, selected;
  logic [7:0] tx_byte;
  shbg_rx_t   rx_data;
  int         fails;      // Mismatches seen
  int         num_checks; // Comparisons made
  int         starts;     // Write commits counted

  shbg_guard dut (
    .clock              (clock),
    .rst_b              (rst_b),
    .cs_b               (cs_b),
    .sck                (sck),
    .si                 (si),
    .hold_b             (hold_b),
    .so_out             (so_out),
    .so_oe_b            (so_oe_b),
    .supply_low         (supply_low),
    .so_enable          (so_enable),
    .tx_byte            (tx_byte),
    .rx_valid           (rx_valid),
    .rx_ready           (rx_ready),
    .rx_data            (rx_data),
    .write_enable_latch (write_enable_latch),
    .write_start        (write_start),
    .write_is_status    (write_is_status),
    .write_abort        (write_abort),
    .overrun            (overrun),
    .paused             (paused),
    .selected           (selected)
  );
  shbg_host host (
    .clock   (clock),
    .so_out  (so_out),
    .so_oe_b (so_oe_b),
    .cs_b    (cs_b),
    .sck     (sck),
    .si      (si),
    .hold_b  (hold_b)
  );

  ////////////////////////////////////////////////////////////
  // Clock, commit counter and hang guard
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    if (write_start === 1'b1) begin
      starts++;
    end
  end

  // Whole run is about 7000 clocks; 25000 leaves ample room
  initial begin
    #100000;
    fails++;
    final_report();
  end

  task automatic final_report();
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkn(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Check the head of the byte stream, then pop it with a one-edge ready
  task automatic pop(input logic f, input logic [7:0] d);
    @(negedge clock);
    chk1("rx_valid", 1'b1, rx_valid);
    chk1("rx_first", f, rx_data.first);
    chk8("rx_byte", d, rx_data.data);
    @(posedge clock);
    rx_ready <= 1'b1;
    @(posedge clock);
    rx_ready <= 1'b0;
  endtask

  // Arm the latch with a one-byte frame
  task automatic write_enable_cmd();
    host.sel(1'b1);
    host.xfer(WRITE_ENABLE_CMD, 8);
    host.sel(1'b0);
    pop(1'b1, WRITE_ENABLE_CMD);
  endtask

  // Frame of opcode plus one data byte
  task automatic frame(input logic [7:0] op, input logic [7:0] d);
    host.sel(1'b1);
    host.xfer(op, 8);
    host.xfer(d, 8);
    host.sel(1'b0);
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios
  // Latch arms; the transmit byte leaves MSB first while selected
  task automatic s_enable();
    @(posedge clock);
    so_enable <= 1'b1;
    tx_byte   <= 8'hA5;
    host.sel(1'b1);
    host.xfer(WRITE_ENABLE_CMD, 8);
    chk8("so_byte", 8'hA5, host.so_seen);
    host.sel(1'b0);
    @(negedge clock);
    chk1("write_enable_latch", 1'b1, write_enable_latch);
    pop(1'b1, WRITE_ENABLE_CMD);
  endtask

  // Memory then status write each commit once and use up the latch
  task automatic s_writes();
    logic [7:0] cmd [2] = '{MEM_WRITE_CMD, STATUS_WRITE_CMD};
    int s0;
    for (int k = 0; k < 2; k++) begin
      write_enable_cmd();
      s0 = starts;
      frame(cmd[k], 8'h3C);
      @(negedge clock);
      chkn("write_starts", s0 + 1, starts);
      chk1("write_is_status", k == 1, write_is_status);
      chk1("write_enable_latch", 1'b0, write_enable_latch);
      pop(1'b1, cmd[k]);
      pop(1'b0, 8'h3C);
    end
    write_enable_cmd();
    host.sel(1'b1);
    host.xfer(WRITE_DISABLE_STATE_CMD, 8);
    host.sel(1'b0);
    @(negedge clock);
    chk1("write_enable_latch", 1'b0, write_enable_latch);
    pop(1'b1, WRITE_DISABLE_STATE_CMD);
  endtask

  // Pause taken with the clock low: at once, output floats, byte resumes intact
  task automatic s_pause_low();
    int s0;
    write_enable_cmd();
    s0 = starts;
    host.sel(1'b1);
    host.xfer(MEM_WRITE_CMD, 8);
    host.xfer(8'hC3, 4);
    @(negedge clock);
    chk1("so_oe_b", 1'b0, so_oe_b);
    host.hold(1'b1);
    @(negedge clock);
    chk1("paused", 1'b1, paused);
    chk1("so_oe_b", 1'b1, so_oe_b);
    host.xfer(8'hFF, 3);
    host.hold(1'b0);
    @(negedge clock);
    chk1("paused", 1'b0, paused);
    host.xfer(8'h30, 4);
    host.sel(1'b0);
    @(negedge clock);
    chkn("write_starts", s0 + 1, starts);
    pop(1'b1, MEM_WRITE_CMD);
    pop(1'b0, 8'hC3);
  endtask

  // Pause moved with the clock high waits for the next falling clock
  task automatic s_pause_high();
    host.sel(1'b1);
    host.xfer(8'hB5, 4);
    host.step(1'b1, 1'b0);
    host.hold(1'b1);
    @(negedge clock);
    chk1("paused", 1'b0, paused);
    host.step(1'b0, 1'b0);
    @(negedge clock);
    chk1("paused", 1'b1, paused);
    host.step(1'b1, 1'b1);
    host.hold(1'b0);
    @(negedge clock);
    chk1("paused", 1'b1, paused);
    host.step(1'b0, 1'b0);
    @(negedge clock);
    chk1("paused", 1'b0, paused);
    host.xfer(8'hA0, 3);
    host.sel(1'b0);
    pop(1'b1, 8'hB5);
  endtask

  // Deselect in mid-pause ends the operation with nothing committed
  task automatic s_desel_pause();
    int s0;
    write_enable_cmd();
    s0 = starts;
    host.sel(1'b1);
    host.xfer(MEM_WRITE_CMD, 8);
    host.xfer(8'h11, 8);
    host.hold(1'b1);
    host.sel(1'b0);
    host.hold(1'b0);
    @(negedge clock);
    chkn("write_starts", s0, starts);
    chk1("paused", 1'b0, paused);
    chk1("selected", 1'b0, selected);
    pop(1'b1, MEM_WRITE_CMD);
    pop(1'b0, 8'h11);
  endtask

  // Supply drop mid-frame aborts the write; a later write needs a new enable
  task automatic s_supply();
    int s0;
    write_enable_cmd();
    s0 = starts;
    host.sel(1'b1);
    host.xfer(MEM_WRITE_CMD, 8);
    host.xfer(8'h55, 8);
    @(posedge clock);
    supply_low <= 1'b1;
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk1("write_abort", 1'b1, write_abort);
    chk1("write_enable_latch", 1'b0, write_enable_latch);
    @(posedge clock);
    supply_low <= 1'b0;
    host.sel(1'b0);
    @(negedge clock);
    chk1("write_abort", 1'b0, write_abort);
    chkn("write_starts", s0, starts);
    pop(1'b1, MEM_WRITE_CMD);
    pop(1'b0, 8'h55);
    frame(MEM_WRITE_CMD, 8'h66);
    @(negedge clock);
    chkn("write_starts", s0, starts);
    pop(1'b1, MEM_WRITE_CMD);
    pop(1'b0, 8'h66);
  endtask

  // Clocking while deselected delivers no bytes and starts no write
  task automatic s_desel_clock();
    int s0;
    write_enable_cmd();
    s0 = starts;
    host.xfer(MEM_WRITE_CMD, 8);
    host.xfer(8'h77, 8);
    host.sel(1'b0);
    @(negedge clock);
    chk1("rx_valid", 1'b0, rx_valid);
    chkn("write_starts", s0, starts);
  endtask

  // Power-on mid-run: reset drops an armed latch and shows abort; no write follows
  task automatic s_power_on();
    int s0;
    write_enable_cmd();
    s0 = starts;
    @(negedge clock);
    chk1("write_enable_latch", 1'b1, write_enable_latch);
    @(posedge clock);
    rst_b <= 1'b0;
    @(negedge clock);
    chk1("write_abort", 1'b1, write_abort);
    chk1("write_enable_latch", 1'b0, write_enable_latch);
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (6) @(posedge clock);
    frame(MEM_WRITE_CMD, 8'h5A);
    @(negedge clock);
    chk1("write_abort", 1'b0, write_abort);
    chkn("write_starts", s0, starts);
    pop(1'b1, MEM_WRITE_CMD);
    pop(1'b0, 8'h5A);
  endtask

  // Fill the buffer past its depth with the drain stalled, then empty it
  task automatic s_fifo();
    host.sel(1'b1);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      host.xfer(8'(i), 8);
    end
    host.sel(1'b0);
    @(negedge clock);
    chk1("overrun", 1'b1, overrun);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      pop(i == 0, 8'(i));
    end
    @(negedge clock);
    chk1("rx_valid", 1'b0, rx_valid);
    host.sel(1'b1);
    @(negedge clock);
    chk1("overrun", 1'b0, overrun);
    host.sel(1'b0);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst_b      = 1'b0;
    supply_low = 1'b0;
    so_enable  = 1'b0;
    tx_byte    = 8'h00;
    rx_ready   = 1'b0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (6) @(posedge clock);
    s_enable();
    s_writes();
    s_pause_low();
    s_pause_high();
    s_desel_pause();
    s_supply();
    s_desel_clock();
    s_power_on();
    s_fifo();
    final_report();
  end
endmodule
